// ---- core/asa_alu_regs.svh ----
// register map, field positions and constants of the add/sub alu
// Summary of operation
// - addition sets carry on carry out of the result msb, clears otherwise
// - subtraction sets carry on borrow into the result msb, clears otherwise
// - nibble carry set on carry out of or borrow into the low nibble
// - sign flag copies bit 7 for bytes, bit 15 for words
// - zero flag set when every result bit is zero
// - parity flag set when low eight result bits hold even ones
// - overflow flag set when signed result leaves the destination range
// - sum writes destination plus source and updates all six flags
// - difference writes destination minus source and updates all six flags
// - sum with carry adds one more when carry was set
// - difference with borrow subtracts one more when carry was set
// - increment adds one, updates five flags, keeps carry
// - decrement subtracts one, updates five flags, keeps carry
// - negate forms zero minus operand; carry set unless operand is zero
// - negating the most negative value keeps it and sets overflow
// - compare updates all six flags and leaves both operands unchanged
// - ascii sum adjust makes one digit, upper nibble zero, updates nibble carry, carry
// - bcd sum adjust makes two digits, updates five flags, overflow kept
// - ascii difference adjust makes one digit, upper nibble zero, updates two flags
// - bcd difference adjust makes two digits, updates five flags, overflow kept
`ifndef ASA_ALU_REGS_SVH
`define ASA_ALU_REGS_SVH

`define ASA_OFF_DEST   8'h00
`define ASA_OFF_SRC    8'h04
`define ASA_OFF_CTRL   8'h08
`define ASA_OFF_FLAGS  8'h0C

`define ASA_CTRL_OP_HI 3
`define ASA_CTRL_OP_LO 0
`define ASA_CTRL_WORD  4

`define ASA_FLAG_CARRY  0
`define ASA_FLAG_PARITY 2
`define ASA_FLAG_NIBBLE 4
`define ASA_FLAG_ZERO   6
`define ASA_FLAG_SIGN   7
`define ASA_FLAG_OVFL   11

`define ASA_RESP_OKAY  2'h0
`define ASA_RESP_SLVERR 2'h2

`define ASA_NIB_MAX    4'h9
`define ASA_BCD_MAX    8'h99
`define ASA_ADJ_LO     8'h06
`define ASA_ADJ_HI     8'h60
`define ASA_NIB_MASK   8'h0F
`define ASA_BYTE_MIN   8'h80
`define ASA_WORD_MIN   16'h8000
`define ASA_ONE        16'h0001
`define ASA_ZERO16     16'h0000
`define ASA_ZERO32     32'h0000_0000

`endif

// ---- core/asa_pkg.sv ----
// types of the add/sub alu
package asa_pkg;

  typedef enum logic [3:0] {
    ASA_OP_ADD        = 4'h0,
    ASA_OP_ADC        = 4'h1,
    ASA_OP_INC        = 4'h2,
    ASA_OP_ASCII_SUM  = 4'h3,
    ASA_OP_BCD_SUM    = 4'h4,
    ASA_OP_SUB        = 4'h5,
    ASA_OP_SUB_BORROW = 4'h6,
    ASA_OP_MINUS_ONE  = 4'h7,
    ASA_OP_REVERSE    = 4'h8,
    ASA_OP_COMPARE    = 4'h9,
    ASA_OP_ASCII_DIFF = 4'hA,
    ASA_OP_BCD_DIFF   = 4'hB
  } asa_op_t;

  typedef enum logic {
    ASA_WR_IDLE = 1'b0,
    ASA_WR_RESP = 1'b1
  } asa_wr_state_t;

  typedef struct packed {
    logic carry_flag;
    logic even_parity_flag;
    logic nibble_carry_flag;
    logic result_zero_flag;
    logic sign_bit_flag;
    logic signed_overflow_flag;
  } asa_flags_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] prot;
  } asa_axi_addr_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
  } asa_axi_wdata_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } asa_axi_rdata_t;

endpackage

// ---- core/asa_alu.sv ----
// add/sub alu with flags behind an axi4-lite slave
`timescale 1ns/1ps
`include "asa_alu_regs.svh"

module asa_alu (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire asa_pkg::asa_axi_addr_t  aw,
  input  wire logic                    wvalid,
  output logic                         wready,
  input  wire asa_pkg::asa_axi_wdata_t w,
  output logic                         bvalid,
  input  wire logic                    bready,
  output logic [1:0]                   bresp,
  input  wire logic                    arvalid,
  output logic                         arready,
  input  wire asa_pkg::asa_axi_addr_t  ar,
  output logic                         rvalid,
  input  wire logic                    rready,
  output asa_pkg::asa_axi_rdata_t      r,
  output logic [15:0]                  accumulator,
  output asa_pkg::asa_flags_t          flags
);
  import asa_pkg::*;

  asa_wr_state_t  wr_state_reg;
  logic           aw_held_reg;
  logic           w_held_reg;
  logic [7:0]     waddr_reg;
  asa_axi_wdata_t wdata_reg;
  logic [1:0]     bresp_reg;
  logic           rvalid_reg;
  asa_axi_rdata_t rdata_reg;
  logic [15:0]    dest_reg;
  logic [15:0]    src_reg;
  logic [4:0]     ctrl_reg;
  asa_flags_t     flags_reg;
  logic [15:0]    prev_dest_q;
  logic [15:0]    prev_src_q;

  logic           do_write;
  logic           exec;
  asa_op_t        op_in;
  logic           word_in;
  logic           op_valid;
  logic [15:0]    opa;
  logic [15:0]    opb;
  logic           cin;
  logic           sub;
  logic           keep_cf;
  logic [16:0]    sum_w;
  logic [8:0]     sum_b;
  logic [4:0]     sum_n;
  logic [15:0]    dest_next;
  asa_flags_t     flags_next;
  logic           write_dest;
  logic [15:0]    res;
  logic           res_msb;
  logic           a_msb;
  logic           b_msb;
  logic [7:0]     acc_lo;
  logic [7:0]     adj;
  logic           lo_fix;
  logic           hi_fix;
  logic [31:0]    rd_word;
  logic           rd_hit;
  logic [31:0]    flag_word;

  // axi write and read channel handshakes and output ports
  assign awready  = (wr_state_reg == ASA_WR_IDLE) && !aw_held_reg;
  assign wready   = (wr_state_reg == ASA_WR_IDLE) && !w_held_reg;
  assign bvalid   = (wr_state_reg == ASA_WR_RESP);
  assign bresp    = bresp_reg;
  assign do_write = (wr_state_reg == ASA_WR_IDLE) && aw_held_reg && w_held_reg;
  assign exec     = do_write && (waddr_reg == `ASA_OFF_CTRL) && wdata_reg.strb[0];
  assign arready  = !rvalid_reg;
  assign rvalid   = rvalid_reg;
  assign r        = rdata_reg;
  assign accumulator = dest_reg;
  assign flags    = flags_reg;

  // write address and data latches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      waddr_reg   <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held_reg <= 1'b1;
      waddr_reg   <= aw.addr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
    end else if (wvalid && wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= w;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // write response state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= ASA_WR_IDLE;
      bresp_reg    <= `ASA_RESP_OKAY;
    end else begin
      case (wr_state_reg)
        ASA_WR_IDLE: begin
          if (do_write) begin
            wr_state_reg <= ASA_WR_RESP;
            if (waddr_reg == `ASA_OFF_DEST || waddr_reg == `ASA_OFF_SRC ||
                waddr_reg == `ASA_OFF_CTRL || waddr_reg == `ASA_OFF_FLAGS) begin
              bresp_reg <= `ASA_RESP_OKAY;
            end else begin
              bresp_reg <= `ASA_RESP_SLVERR;
            end
          end
        end
        ASA_WR_RESP: begin
          if (bready) begin
            wr_state_reg <= ASA_WR_IDLE;
          end
        end
        default: wr_state_reg <= ASA_WR_IDLE;
      endcase
    end
  end

  // operand selection
  always_comb begin
    op_in    = asa_op_t'(wdata_reg.data[`ASA_CTRL_OP_HI:`ASA_CTRL_OP_LO]);
    word_in  = wdata_reg.data[`ASA_CTRL_WORD];
    opa      = dest_reg;
    opb      = src_reg;
    cin      = 1'b0;
    sub      = 1'b0;
    keep_cf  = 1'b0;
    op_valid = 1'b1;
    case (op_in)
      ASA_OP_ADD: begin
      end
      ASA_OP_ADC: cin = flags_reg.carry_flag;
      ASA_OP_INC: begin
        opb     = `ASA_ONE;
        keep_cf = 1'b1;
      end
      ASA_OP_SUB: sub = 1'b1;
      ASA_OP_SUB_BORROW: begin
        sub = 1'b1;
        cin = flags_reg.carry_flag;
      end
      ASA_OP_MINUS_ONE: begin
        opb     = `ASA_ONE;
        sub     = 1'b1;
        keep_cf = 1'b1;
      end
      ASA_OP_REVERSE: begin
        opa = `ASA_ZERO16;
        opb = dest_reg;
        sub = 1'b1;
      end
      ASA_OP_COMPARE: sub = 1'b1;
      ASA_OP_ASCII_SUM, ASA_OP_BCD_SUM, ASA_OP_ASCII_DIFF, ASA_OP_BCD_DIFF: begin
      end
      default: op_valid = 1'b0;
    endcase
  end

  // carry or borrow at the msb
  assign sum_w = sub ? ({1'b0, opa} - {1'b0, opb} - {16'h0000, cin})
                     : ({1'b0, opa} + {1'b0, opb} + {16'h0000, cin});
  assign sum_b = sub ? ({1'b0, opa[7:0]} - {1'b0, opb[7:0]} - {8'h00, cin})
                     : ({1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, cin});
  // carry or borrow at the low nibble
  assign sum_n = sub ? ({1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin})
                     : ({1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin});

  assign acc_lo = dest_reg[7:0];
  assign lo_fix = (acc_lo[3:0] > `ASA_NIB_MAX) || flags_reg.nibble_carry_flag;
  assign hi_fix = (acc_lo > `ASA_BCD_MAX) || flags_reg.carry_flag;

  // result and flag computation
  always_comb begin
    res        = word_in ? sum_w[15:0] : {dest_reg[15:8], sum_b[7:0]};
    res_msb    = word_in ? res[15] : res[7];
    a_msb      = word_in ? opa[15] : opa[7];
    b_msb      = word_in ? opb[15] : opb[7];
    adj        = acc_lo;
    dest_next  = dest_reg;
    flags_next = flags_reg;
    write_dest = 1'b0;
    case (op_in)
      ASA_OP_ASCII_SUM, ASA_OP_ASCII_DIFF: begin
        if (op_in == ASA_OP_ASCII_SUM) begin
          adj = lo_fix ? (acc_lo + `ASA_ADJ_LO) : acc_lo;
        end else begin
          adj = lo_fix ? (acc_lo - `ASA_ADJ_LO) : acc_lo;
        end
        dest_next  = {dest_reg[15:8], adj & `ASA_NIB_MASK};
        write_dest = 1'b1;
        flags_next.nibble_carry_flag = lo_fix;
        flags_next.carry_flag        = lo_fix;
      end
      ASA_OP_BCD_SUM, ASA_OP_BCD_DIFF: begin
        if (op_in == ASA_OP_BCD_SUM) begin
          adj = acc_lo + (lo_fix ? `ASA_ADJ_LO : 8'h00) + (hi_fix ? `ASA_ADJ_HI : 8'h00);
        end else begin
          adj = acc_lo - (lo_fix ? `ASA_ADJ_LO : 8'h00) - (hi_fix ? `ASA_ADJ_HI : 8'h00);
        end
        dest_next  = {dest_reg[15:8], adj};
        write_dest = 1'b1;
        flags_next.nibble_carry_flag = lo_fix;
        flags_next.carry_flag        = hi_fix;
        flags_next.even_parity_flag  = ~^adj;
        flags_next.sign_bit_flag     = adj[7];
        flags_next.result_zero_flag  = (adj == 8'h00);
      end
      default: begin
        dest_next  = res;
        write_dest = op_valid && (op_in != ASA_OP_COMPARE);
        if (op_valid) begin
          if (!keep_cf) begin
            flags_next.carry_flag = word_in ? sum_w[16] : sum_b[8];
          end
          flags_next.nibble_carry_flag = sum_n[4];
          flags_next.sign_bit_flag     = res_msb;
          flags_next.result_zero_flag  = word_in ? (res == `ASA_ZERO16) : (res[7:0] == 8'h00);
          flags_next.even_parity_flag  = ~^res[7:0];
          flags_next.signed_overflow_flag = sub ? ((a_msb != b_msb) && (res_msb != a_msb))
                                                : ((a_msb == b_msb) && (res_msb != a_msb));
        end
      end
    endcase
  end

  // destination operand register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dest_reg <= `ASA_ZERO16;
    end else if (exec && write_dest) begin
      dest_reg <= dest_next;
    end else if (do_write && waddr_reg == `ASA_OFF_DEST) begin
      if (wdata_reg.strb[0]) dest_reg[7:0] <= wdata_reg.data[7:0];
      if (wdata_reg.strb[1]) dest_reg[15:8] <= wdata_reg.data[15:8];
    end
  end

  // source operand register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_reg <= `ASA_ZERO16;
    end else if (do_write && waddr_reg == `ASA_OFF_SRC) begin
      if (wdata_reg.strb[0]) src_reg[7:0] <= wdata_reg.data[7:0];
      if (wdata_reg.strb[1]) src_reg[15:8] <= wdata_reg.data[15:8];
    end
  end

  // control register keeps the last operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= 5'h00;
    end else if (exec) begin
      ctrl_reg <= wdata_reg.data[`ASA_CTRL_WORD:`ASA_CTRL_OP_LO];
    end
  end

  // flag register, software writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= '0;
    end else if (exec) begin
      flags_reg <= flags_next;
    end else if (do_write && waddr_reg == `ASA_OFF_FLAGS) begin
      if (wdata_reg.strb[0]) begin
        flags_reg.carry_flag        <= wdata_reg.data[`ASA_FLAG_CARRY];
        flags_reg.even_parity_flag  <= wdata_reg.data[`ASA_FLAG_PARITY];
        flags_reg.nibble_carry_flag <= wdata_reg.data[`ASA_FLAG_NIBBLE];
        flags_reg.result_zero_flag  <= wdata_reg.data[`ASA_FLAG_ZERO];
        flags_reg.sign_bit_flag     <= wdata_reg.data[`ASA_FLAG_SIGN];
      end
      if (wdata_reg.strb[1]) begin
        flags_reg.signed_overflow_flag <= wdata_reg.data[`ASA_FLAG_OVFL];
      end
    end
  end

  // read decode
  always_comb begin
    flag_word = `ASA_ZERO32;
    flag_word[`ASA_FLAG_CARRY]  = flags_reg.carry_flag;
    flag_word[`ASA_FLAG_PARITY] = flags_reg.even_parity_flag;
    flag_word[`ASA_FLAG_NIBBLE] = flags_reg.nibble_carry_flag;
    flag_word[`ASA_FLAG_ZERO]   = flags_reg.result_zero_flag;
    flag_word[`ASA_FLAG_SIGN]   = flags_reg.sign_bit_flag;
    flag_word[`ASA_FLAG_OVFL]   = flags_reg.signed_overflow_flag;
    rd_hit  = 1'b1;
    rd_word = `ASA_ZERO32;
    if (ar.addr == `ASA_OFF_DEST) begin
      rd_word = {16'h0000, dest_reg};
    end else if (ar.addr == `ASA_OFF_SRC) begin
      rd_word = {16'h0000, src_reg};
    end else if (ar.addr == `ASA_OFF_CTRL) begin
      rd_word = {27'h000_0000, ctrl_reg};
    end else if (ar.addr == `ASA_OFF_FLAGS) begin
      rd_word = flag_word;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
    end else if (arvalid && arready) begin
      rvalid_reg     <= 1'b1;
      rdata_reg.data <= rd_word;
      rdata_reg.resp <= rd_hit ? `ASA_RESP_OKAY : `ASA_RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // operand history for checks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_dest_q <= `ASA_ZERO16;
      prev_src_q  <= `ASA_ZERO16;
    end else begin
      prev_dest_q <= dest_reg;
      prev_src_q  <= src_reg;
    end
  end

  AST_ADD_CARRY: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op_in == ASA_OP_ADD && !word_in |=>
      flags_reg.carry_flag == (({1'b0, prev_dest_q[7:0]} + {1'b0, prev_src_q[7:0]}) > 9'h0FF))
    else $error("add carry wrong");
  AST_SUB_BORROW: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op_in == ASA_OP_SUB && word_in |=>
      flags_reg.carry_flag == (prev_dest_q < prev_src_q) &&
      dest_reg == prev_dest_q - prev_src_q)
    else $error("sub borrow wrong");
  AST_SIGN: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op_valid && op_in == ASA_OP_ADD && word_in |=>
      flags_reg.sign_bit_flag == dest_reg[15])
    else $error("sign flag wrong");
  AST_PARITY: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && (op_in == ASA_OP_SUB || op_in == ASA_OP_BCD_SUM) |=>
      flags_reg.even_parity_flag == ~^dest_reg[7:0])
    else $error("parity flag wrong");
  AST_INC_KEEP_CF: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op_in == ASA_OP_INC |=> $stable(flags_reg.carry_flag))
    else $error("increment changed carry");
  AST_NEG_CF: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op_in == ASA_OP_REVERSE && word_in |=>
      flags_reg.carry_flag == (prev_dest_q != `ASA_ZERO16))
    else $error("negate carry wrong");
  AST_NEG_MIN: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op_in == ASA_OP_REVERSE && word_in && dest_reg == `ASA_WORD_MIN |=>
      dest_reg == `ASA_WORD_MIN && flags_reg.signed_overflow_flag)
    else $error("negate minimum wrong");
  AST_CMP_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op_in == ASA_OP_COMPARE |=> $stable(dest_reg) ##1 1'b1)
    else $error("compare changed destination");
  AST_ASCII_SUM_NIB: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op_in == ASA_OP_ASCII_SUM |=>
      dest_reg[7:4] == 4'h0 && flags_reg.carry_flag == flags_reg.nibble_carry_flag)
    else $error("ascii adjust wrong");

endmodule // asa_alu

// ---- dv/asa_host_model.sv ----
// axi4-lite master standing in for the instruction decoder and register file
`timescale 1ns/1ps

module asa_host_model (
  input  wire logic                    aclk,
  output logic                         awvalid,
  input  wire logic                    awready,
  output asa_pkg::asa_axi_addr_t       aw,
  output logic                         wvalid,
  input  wire logic                    wready,
  output asa_pkg::asa_axi_wdata_t      w,
  input  wire logic                    bvalid,
  output logic                         bready,
  input  wire logic [1:0]              bresp,
  output logic                         arvalid,
  input  wire logic                    arready,
  output asa_pkg::asa_axi_addr_t       ar,
  input  wire logic                    rvalid,
  output logic                         rready,
  input  wire asa_pkg::asa_axi_rdata_t r,
  output logic                         timed_out
);
  import asa_pkg::*;

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, timed_out} = '0;
    aw = '0;
    w = '0;
    ar = '0;
  end

  // one write: address and data offered together, each released when taken
  task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] resp);
    int n;
    @(posedge aclk);
    awvalid <= 1'b1;
    aw      <= '{addr: a, prot: 3'h0};
    wvalid  <= 1'b1;
    w       <= '{data: d, strb: s};
    bready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        aw      <= ~aw;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        w      <= ~w;
      end
      if (bvalid && bready) break;
    end
    if (n == 200) timed_out <= 1'b1;
    resp = bresp;
    bready <= 1'b0;
  endtask

  // one read: address held until taken, rready held until rvalid is seen
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    ar      <= '{addr: a, prot: 3'h0};
    rready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        ar      <= ~ar;
      end
      if (rvalid && rready) break;
    end
    if (n == 200) timed_out <= 1'b1;
    d = r.data;
    resp = r.resp;
    rready <= 1'b0;
  endtask
endmodule // asa_host_model

// ---- dv/tb_top.sv ----
// self-checking bench of the add/sub alu
`timescale 1ns/1ps
`include "asa_alu_regs.svh"

module tb_top;
  import asa_pkg::*;

  logic           aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic           arvalid, arready, rvalid, rready, timed_out;
  logic [1:0]     bresp;
  asa_axi_addr_t  aw, ar;
  asa_axi_wdata_t w;
  asa_axi_rdata_t r;
  logic [15:0]    accumulator;
  asa_flags_t     flags;
  int             n_errors = 0;
  int             checked = 0;

  asa_alu i_asa_alu (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .aw(aw), .wvalid(wvalid), .wready(wready), .w(w), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .ar(ar), .rvalid(rvalid),
    .rready(rready), .r(r), .accumulator(accumulator), .flags(flags));

  asa_host_model i_asa_host_model (.aclk(aclk), .awvalid(awvalid), .awready(awready),
    .aw(aw), .wvalid(wvalid), .wready(wready), .w(w), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .ar(ar), .rvalid(rvalid),
    .rready(rready), .r(r), .timed_out(timed_out));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge aclk) begin
    if (timed_out === 1'b1) begin
      n_errors++;
      $display("FAIL %0t bus wait ran out", $time);
      tally_and_finish();
    end
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [31:0] pack(input asa_flags_t f);
    return {20'h0_0000, f.signed_overflow_flag, 3'h0, f.sign_bit_flag, f.result_zero_flag,
            1'b0, f.nibble_carry_flag, 1'b0, f.even_parity_flag, 1'b0, f.carry_flag};
  endfunction

  // expected destination and flags of one operation
  function automatic void model_op(input logic [3:0] op, input logic wd, input logic [15:0] d,
      input logic [15:0] s, input asa_flags_t f, output logic [15:0] q, output asa_flags_t o);
    logic [16:0] a, b, c, res;
    logic [15:0] m;
    logic [7:0]  acc;
    logic        sub, lo, hi;
    int          hb;
    o = f;
    q = d;
    m = wd ? 16'hFFFF : 16'h00FF;
    hb = wd ? 15 : 7;
    sub = op inside {4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
    a = {1'b0, d & m};
    b = {1'b0, s & m};
    c = '0;
    if (op == 4'h1 || op == 4'h6) c = {16'h0000, f.carry_flag};
    if (op == 4'h2 || op == 4'h7) b = 17'h0_0001;
    if (op == 4'h8) begin
      b = a;
      a = '0;
    end
    res = sub ? a - b - c : a + b + c;
    lo = (d[3:0] > 4'h9) || f.nibble_carry_flag;
    hi = (d[7:0] > 8'h99) || f.carry_flag;
    acc = d[7:0];
    if (op <= 4'h2 || sub) begin
      if (op != 4'h2 && op != 4'h7) o.carry_flag = res[hb+1];
      o.nibble_carry_flag = a[4] ^ b[4] ^ res[4];
      o.signed_overflow_flag = sub ? (a[hb] != b[hb] && res[hb] != a[hb])
                                   : (a[hb] == b[hb] && res[hb] != a[hb]);
      o.sign_bit_flag = res[hb];
      o.result_zero_flag = (res[15:0] & m) == 16'h0000;
      o.even_parity_flag = ~^res[7:0];
      if (op != 4'h9) q = (d & ~m) | (res[15:0] & m);
    end else if (op <= 4'hB) begin
      case (op)
        4'h3: acc = (acc + (lo ? 8'h06 : 8'h00)) & 8'h0F;
        4'hA: acc = (acc - (lo ? 8'h06 : 8'h00)) & 8'h0F;
        4'h4: acc = acc + (lo ? 8'h06 : 8'h00) + (hi ? 8'h60 : 8'h00);
        default: acc = acc - (lo ? 8'h06 : 8'h00) - (hi ? 8'h60 : 8'h00);
      endcase
      o.nibble_carry_flag = lo;
      o.carry_flag = (op == 4'h4 || op == 4'hB) ? hi : lo;
      if (op == 4'h4 || op == 4'hB) begin
        o.sign_bit_flag = acc[7];
        o.result_zero_flag = acc == 8'h00;
        o.even_parity_flag = ~^acc;
      end
      q = {d[15:8], acc};
    end
  endfunction

  // load operands and flags, execute, compare result and flags
  task automatic run(input logic [3:0] op, input logic wd, input logic [15:0] d,
                     input logic [15:0] s, input logic [5:0] fl);
    logic [15:0] eq;
    asa_flags_t  ef;
    logic [1:0]  rs;
    model_op(op, wd, d, s, asa_flags_t'(fl), eq, ef);
    i_asa_host_model.write(`ASA_OFF_DEST, {16'h0000, d}, 4'h3, rs);
    i_asa_host_model.write(`ASA_OFF_SRC, {16'h0000, s}, 4'h3, rs);
    i_asa_host_model.write(`ASA_OFF_FLAGS, pack(asa_flags_t'(fl)), 4'h3, rs);
    i_asa_host_model.write(`ASA_OFF_CTRL, {27'h000_0000, wd, op}, 4'h1, rs);
    check_val(32'(rs), 32'(`ASA_RESP_OKAY), "execute response");
    check_val(32'(accumulator), 32'(eq), "result");
    check_val(32'(flags), 32'(ef), "flags");
  endtask

  task automatic t_add;
    run(4'h0, 1'b0, 16'h12FF, 16'h0001, 6'h00);
    run(4'h0, 1'b1, 16'h7FFF, 16'h0001, 6'h00);
    run(4'h1, 1'b0, 16'h0040, 16'h003F, 6'h20);
    run(4'h1, 1'b1, 16'hFFFF, 16'h0000, 6'h20);
    run(4'h2, 1'b0, 16'h00FF, 16'h0000, 6'h20);
    run(4'h2, 1'b1, 16'h7FFF, 16'h0000, 6'h00);
    $display("test add done");
  endtask

  task automatic t_sub;
    run(4'h5, 1'b0, 16'h3400, 16'h0001, 6'h00);
    run(4'h5, 1'b1, 16'h8000, 16'h0001, 6'h00);
    run(4'h6, 1'b0, 16'h0005, 16'h0005, 6'h20);
    run(4'h6, 1'b1, 16'h0010, 16'h0001, 6'h00);
    run(4'h7, 1'b0, 16'h0080, 16'h0000, 6'h20);
    run(4'h7, 1'b1, 16'h0000, 16'h0000, 6'h00);
    $display("test sub done");
  endtask

  task automatic t_negate_compare;
    logic [31:0] d;
    logic [1:0]  rs;
    run(4'h8, 1'b0, 16'h5580, 16'h0000, 6'h00);
    run(4'h8, 1'b1, 16'h8000, 16'h0000, 6'h00);
    run(4'h8, 1'b0, 16'h0000, 16'h0000, 6'h3F);
    run(4'h8, 1'b1, 16'h0005, 16'h0000, 6'h00);
    run(4'h9, 1'b1, 16'h8000, 16'h0001, 6'h00);
    run(4'h9, 1'b0, 16'h0003, 16'h0005, 6'h00);
    i_asa_host_model.read(`ASA_OFF_SRC, d, rs);
    check_val(d, 32'h0000_0005, "compare source kept");
    i_asa_host_model.read(`ASA_OFF_DEST, d, rs);
    check_val(d, 32'h0000_0003, "compare destination kept");
    $display("test negate compare done");
  endtask

  // adjusts always target the accumulator low byte, with decimal and non-decimal digits such as 7D and FF
  task automatic t_adjust;
    run(4'h4, 1'b0, 16'h127D, 16'h0000, 6'h00);
    run(4'h4, 1'b0, 16'h0032, 16'h0000, 6'h29);
    run(4'hB, 1'b0, 16'h00FF, 16'h0000, 6'h28);
    run(4'hB, 1'b0, 16'h0023, 16'h0000, 6'h01);
    run(4'h3, 1'b0, 16'h340B, 16'h0000, 6'h00);
    run(4'h3, 1'b0, 16'h0012, 16'h0000, 6'h0F);
    run(4'hA, 1'b0, 16'h00FF, 16'h0000, 6'h08);
    run(4'hA, 1'b0, 16'h0004, 16'h0000, 6'h3F);
    $display("test adjust done");
  endtask

  task automatic t_bus;
    logic [31:0] d;
    logic [1:0]  rs;
    i_asa_host_model.write(8'h10, 32'h0000_FFFF, 4'hF, rs);
    check_val(32'(rs), 32'(`ASA_RESP_SLVERR), "unmapped write response");
    i_asa_host_model.read(8'h10, d, rs);
    check_val(32'(rs), 32'(`ASA_RESP_SLVERR), "unmapped read response");
    check_val(d, 32'h0000_0000, "unmapped read data");
    i_asa_host_model.write(`ASA_OFF_FLAGS, 32'hFFFF_FFFF, 4'hF, rs);
    i_asa_host_model.read(`ASA_OFF_FLAGS, d, rs);
    check_val(d, 32'h0000_08D5, "flag word readback");
    check_val(32'(flags), 32'h0000_003F, "flag port after write");
    run(4'hC, 1'b1, 16'h1234, 16'h1111, 6'h15);
    i_asa_host_model.read(`ASA_OFF_CTRL, d, rs);
    check_val(d, 32'h0000_001C, "last operation readback");
    i_asa_host_model.write(`ASA_OFF_DEST, 32'h0000_ABCD, 4'h2, rs);
    check_val(32'(accumulator), 32'h0000_AB34, "high byte strobe write");
    $display("test bus done");
  endtask

  initial begin
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_val(32'(accumulator), 32'h0000_0000, "accumulator after reset");
    check_val(32'(flags), 32'h0000_0000, "flags after reset");
    t_add();
    t_sub();
    t_negate_compare();
    t_adjust();
    t_bus();
    tally_and_finish();
  end
endmodule // tb_top
